// [rtl/ipc_pkg.sv]
// shared constants and types for the pump, cap and cartridge control
package ipc_pkg;

    // clock rate and vent timing
    localparam int IPC_CLK_MHZ = 100;
    localparam int IPC_VENT_US = 20;
    localparam int IPC_VENT_CYC_I = IPC_VENT_US * IPC_CLK_MHZ;
    localparam logic [10:0] IPC_VENT_CYC = 11'(IPC_VENT_CYC_I);

    // printed lines between an empty pack and the ink-end indication
    localparam logic [7:0] IPC_LINE_LIMIT = 8'hC8;

    // bit positions inside the sensor synchroniser pair
    localparam int IPC_SNS_ABSENT = 0;
    localparam int IPC_SNS_EMPTY = 1;

    // motor state machine
    typedef enum logic [1:0] {
        IPC_ST_STOP = 2'b00,
        IPC_ST_FWD = 2'b01,
        IPC_ST_REV = 2'b10,
        IPC_ST_VENT = 2'b11
    } ipc_state_t;

    // requests from the cpu side
    typedef struct packed {
        logic fwd_req;
        logic rev_req;
        logic vent_req;
    } ipc_cmd_t;

    // motor bridge drive
    typedef struct packed {
        logic forward_cmd;
        logic reverse_cmd;
    } ipc_motor_t;

    // status seen by software
    typedef struct packed {
        logic ink_empty;
        logic cart_absent;
        logic ink_end;
        logic pumping;
        logic brushing;
        logic cap_closed;
        logic suction;
    } ipc_stat_t;

    // whole state of the controller
    typedef struct packed {
        ipc_state_t state;
        logic [10:0] vent_cnt;
        logic [7:0] line_cnt;
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic sucked;
        ipc_motor_t motor;
        logic valve;
        ipc_stat_t stat;
        logic event_p;
    } ipc_regs_t;

    localparam ipc_regs_t IPC_RST = '0;

endpackage : ipc_pkg

// [rtl/ipc_top.sv]
`timescale 1ns/1ps
`default_nettype none

module ipc_top (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire ipc_pkg::ipc_cmd_t i_cmd,
    input wire logic i_line_pulse,
    input wire logic i_ink_empty_in,
    input wire logic i_cart_absent_in,
    output ipc_pkg::ipc_motor_t o_motor,
    output logic o_valve,
    output ipc_pkg::ipc_stat_t o_stat,
    output logic o_event
);
    import ipc_pkg::*;

    ipc_regs_t r_reg;
    ipc_regs_t r_next;

    // qualified requests: asking both ways at once counts as stop
    logic fwd_ok;
    logic rev_ok;
    logic empty_s;
    logic absent_s;

    assign fwd_ok = i_cmd.fwd_req & ~i_cmd.rev_req;
    assign rev_ok = i_cmd.rev_req & ~i_cmd.fwd_req;
    assign empty_s = r_reg.sync2[IPC_SNS_EMPTY];
    assign absent_s = r_reg.sync2[IPC_SNS_ABSENT];

    // next-state logic for the whole controller
    always_comb begin
        r_next = r_reg;
        r_next.event_p = 1'b0;

        // switch pins are asynchronous: two flops before any use
        r_next.sync1 = {i_ink_empty_in, i_cart_absent_in};
        r_next.sync2 = r_reg.sync1;

        // direction changes always pass through stop for one cycle,
        // so the bridge never sees both legs driven
        case (r_reg.state)
            IPC_ST_STOP: begin
                r_next.vent_cnt = '0;
                if (fwd_ok) begin
                    r_next.state = IPC_ST_FWD;
                end else if (rev_ok) begin
                    // reverse opens the cap: vent a held vacuum first
                    if (r_reg.sucked) begin
                        r_next.state = IPC_ST_VENT;
                    end else begin
                        r_next.state = IPC_ST_REV;
                    end
                end
            end
            IPC_ST_FWD: begin
                if (!fwd_ok) begin
                    r_next.state = IPC_ST_STOP;
                end
            end
            IPC_ST_REV: begin
                if (!rev_ok) begin
                    r_next.state = IPC_ST_STOP;
                end
            end
            IPC_ST_VENT: begin
                // vent runs to completion even if the request drops,
                // leaving the cap free to open later
                if (r_reg.vent_cnt == IPC_VENT_CYC - 11'h001) begin
                    r_next.state = IPC_ST_STOP;
                    r_next.vent_cnt = '0;
                end else begin
                    r_next.vent_cnt = r_reg.vent_cnt + 11'h001;
                end
            end
            default: begin
                r_next.state = IPC_ST_STOP;
            end
        endcase

        // full on or off drive, decoded from the state alone
        r_next.motor.forward_cmd = (r_next.state == IPC_ST_FWD);
        r_next.motor.reverse_cmd = (r_next.state == IPC_ST_REV);

        // solenoid opens the valve on request or while venting
        r_next.valve = i_cmd.vent_req | (r_next.state == IPC_ST_VENT);

        // cap position follows the direction actually run
        if (r_reg.motor.forward_cmd) begin
            r_next.stat.cap_closed = 1'b1;
        end else if (r_reg.motor.reverse_cmd) begin
            r_next.stat.cap_closed = 1'b0;
        end

        // activity flags of the pump unit
        r_next.stat.pumping = r_reg.motor.forward_cmd | r_reg.motor.reverse_cmd;
        r_next.stat.brushing = r_reg.motor.forward_cmd;
        r_next.stat.suction = (r_reg.motor.forward_cmd | r_reg.motor.reverse_cmd)
            & r_reg.stat.cap_closed & ~r_reg.valve;

        // a vacuum is left behind by suction until the valve opens
        if (r_reg.stat.suction) begin
            r_next.sucked = 1'b1;
        end else if (r_reg.valve) begin
            r_next.sucked = 1'b0;
        end

        // printed lines counted only on an installed, empty pack
        if (!empty_s || absent_s) begin
            r_next.line_cnt = '0;
        end else if (i_line_pulse && r_reg.line_cnt < IPC_LINE_LIMIT) begin
            r_next.line_cnt = r_reg.line_cnt + 8'h01;
        end

        // sensor decode; empty is only meaningful with a cartridge in
        r_next.stat.cart_absent = absent_s;
        r_next.stat.ink_empty = empty_s & ~absent_s;
        r_next.stat.ink_end = absent_s
            | (empty_s && r_next.line_cnt == IPC_LINE_LIMIT);

        // one-cycle event on any change of cart_absent, ink_empty or ink_end
        r_next.event_p = (r_next.stat.cart_absent != r_reg.stat.cart_absent)
            | (r_next.stat.ink_empty != r_reg.stat.ink_empty)
            | (r_next.stat.ink_end != r_reg.stat.ink_end);
    end

    // single state register, synchronous reset
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            r_reg <= IPC_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // every output comes straight from the state register
    assign o_motor = r_reg.motor;
    assign o_valve = r_reg.valve;
    assign o_stat = r_reg.stat;
    assign o_event = r_reg.event_p;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    a_dir_exclusive: assert property (
        !(o_motor.forward_cmd && o_motor.reverse_cmd))
        else $error("both motor directions driven");

    a_fwd_cmd: assert property (
        (r_reg.state == IPC_ST_STOP && fwd_ok) |=> o_motor.forward_cmd)
        else $error("forward request did not drive forward");

    a_rev_stop: assert property (
        (o_motor.reverse_cmd && !rev_ok) |=> !o_motor.reverse_cmd)
        else $error("reverse drive did not stop at once");

    a_cap_track: assert property (
        o_motor.forward_cmd ##1 o_motor.forward_cmd |-> o_stat.cap_closed)
        else $error("cap not closed after forward run");

    a_cap_open: assert property (
        o_motor.reverse_cmd |=> !o_stat.cap_closed)
        else $error("cap not open after reverse run");

    a_brush_fwd: assert property (
        o_stat.brushing |-> $past(o_motor.forward_cmd))
        else $error("brushing without forward run");

    a_pump_either: assert property (
        (o_motor.forward_cmd || o_motor.reverse_cmd) |=> o_stat.pumping)
        else $error("pumping flag missing while motor runs");

    a_suction_valve: assert property (
        o_stat.suction |-> $past(!o_valve) && $past(o_stat.cap_closed))
        else $error("suction flagged with valve open or cap off");

    a_vent_first: assert property (
        (r_reg.sucked && r_reg.state == IPC_ST_STOP && rev_ok)
        |=> o_valve && !o_motor.reverse_cmd)
        else $error("cap opened without venting");

    // vent length is walked one step at a time against its own counter: one
    // delay spanning the whole vent would be far too long for the tools to unroll
    a_vent_valve: assert property (
        (r_reg.state == IPC_ST_VENT)
        |-> o_valve && !o_motor.forward_cmd && !o_motor.reverse_cmd)
        else $error("vent without valve or with motor running");

    a_vent_start: assert property (
        $rose(r_reg.state == IPC_ST_VENT) |-> r_reg.vent_cnt == 11'h000)
        else $error("vent did not start from a cleared count");

    a_vent_count: assert property (
        (r_reg.state == IPC_ST_VENT && r_reg.vent_cnt != IPC_VENT_CYC - 11'h001)
        |=> r_reg.state == IPC_ST_VENT && r_reg.vent_cnt == $past(r_reg.vent_cnt) + 11'h001)
        else $error("vent ended early or its count skipped");

    a_vent_end: assert property (
        (r_reg.state == IPC_ST_VENT && r_reg.vent_cnt == IPC_VENT_CYC - 11'h001)
        |=> r_reg.state == IPC_ST_STOP)
        else $error("vent overran its time");

    a_absent_now: assert property (
        absent_s |=> o_stat.ink_end && o_stat.cart_absent)
        else $error("missing cartridge not flagged at once");

    a_line_limit: assert property (
        (o_stat.ink_end && !o_stat.cart_absent) |-> r_reg.line_cnt == IPC_LINE_LIMIT)
        else $error("ink end raised before the line limit");

    a_decode_ok: assert property (
        (!empty_s && !absent_s) |=> !o_stat.ink_empty && !o_stat.cart_absent)
        else $error("ink present decoded wrongly");

    a_flag_event: assert property (
        $changed(o_stat.cart_absent) || $changed(o_stat.ink_empty) |-> o_event)
        else $error("flag change without event");

    // motor drive follows the request with no ramp and never jumps legs
    a_fwd_hold: assert property (
        (o_motor.forward_cmd && fwd_ok) |=> o_motor.forward_cmd)
        else $error("forward drive dropped while requested");

    a_fwd_stop: assert property (
        (o_motor.forward_cmd && !fwd_ok) |=> !o_motor.forward_cmd)
        else $error("forward drive did not stop at once");

    a_rev_cmd: assert property (
        (r_reg.state == IPC_ST_STOP && rev_ok && !r_reg.sucked)
        |=> o_motor.reverse_cmd)
        else $error("reverse request did not drive reverse");

    a_idle_stop: assert property (
        (r_reg.state == IPC_ST_STOP) |-> !o_motor.forward_cmd && !o_motor.reverse_cmd)
        else $error("motor driven while stopped");

    a_fwd_to_rev: assert property (
        o_motor.forward_cmd |=> !o_motor.reverse_cmd)
        else $error("forward switched to reverse without a stop");

    a_rev_to_fwd: assert property (
        o_motor.reverse_cmd |=> !o_motor.forward_cmd)
        else $error("reverse switched to forward without a stop");

    a_brush_rev: assert property (
        o_motor.reverse_cmd |=> !o_stat.brushing)
        else $error("brushing during reverse run");

    a_pump_idle: assert property (
        o_stat.pumping |-> $past(o_motor.forward_cmd || o_motor.reverse_cmd))
        else $error("pumping flagged with motor stopped");

    a_valve_req: assert property (
        i_cmd.vent_req |=> o_valve)
        else $error("solenoid request did not open the valve");

    a_valve_cause: assert property (
        o_valve |-> $past(i_cmd.vent_req) || r_reg.state == IPC_ST_VENT)
        else $error("valve open without request or vent");

    a_suction_open: assert property (
        o_valve |=> !o_stat.suction)
        else $error("suction flagged with valve open");

    a_suction_run: assert property (
        (o_motor.forward_cmd && o_stat.cap_closed && !o_valve)
        |=> o_stat.suction)
        else $error("no suction with cap closed and valve shut");

    // the sensor path is three registers deep, so it is only judged once reset
    // has been gone long enough to flush both synchroniser stages
    a_sync_absent: assert property (
        ($past(i_rst_n, 3) && $past(i_rst_n, 2) && $past(i_rst_n))
        |-> o_stat.cart_absent == $past(i_cart_absent_in, 3))
        else $error("cartridge flag does not follow its pin");

    a_decode_empty: assert property (
        ($past(i_rst_n, 3) && $past(i_rst_n, 2) && $past(i_rst_n))
        |-> o_stat.ink_empty
            == ($past(i_ink_empty_in, 3) && !$past(i_cart_absent_in, 3)))
        else $error("ink empty decoded wrongly");

    a_end_event: assert property (
        $changed(o_stat.ink_end) |-> o_event)
        else $error("ink end change without event");

    a_event_cause: assert property (
        o_event |-> $changed(o_stat.cart_absent) || $changed(o_stat.ink_empty)
            || $changed(o_stat.ink_end))
        else $error("event without a flag change");

    // line counter saturates so a long empty run cannot wrap back to zero
    a_count_max: assert property (
        r_reg.line_cnt <= IPC_LINE_LIMIT)
        else $error("line count beyond its limit");

    a_count_clear: assert property (
        (!empty_s || absent_s) |=> r_reg.line_cnt == 8'h00)
        else $error("line count kept without an empty pack");

    a_end_limit: assert property (
        (empty_s && !absent_s && r_reg.line_cnt == IPC_LINE_LIMIT)
        |=> o_stat.ink_end)
        else $error("ink end missing at the line limit");

    a_cap_hold: assert property (
        (!o_motor.forward_cmd && !o_motor.reverse_cmd) |=> $stable(o_stat.cap_closed))
        else $error("cap moved with motor stopped");

endmodule : ipc_top

`default_nettype wire

// [tb/ipc_far.sv]
`timescale 1ns/1ps
`default_nettype none
// far side: motor bridge, cap clutch and cartridge switches
module ipc_far (
    input wire logic i_clk_sys,
    input wire ipc_pkg::ipc_motor_t i_motor,
    input wire logic [1:0] i_cart_mode,
    output logic o_ink_empty_in,
    output logic o_cart_absent_in,
    output logic o_cap_closed,
    output logic o_fault
);
    import ipc_pkg::*;
    // switch pins: mode 0 ink present, 1 pack empty, 2 no cartridge
    assign o_ink_empty_in = (i_cart_mode != 2'h0);
    assign o_cart_absent_in = (i_cart_mode == 2'h2);
    initial o_cap_closed = 1'b0;
    initial o_fault = 1'b0;
    // clutch spring holds the cap at its limit, so only direction counts
    always @(posedge i_clk_sys) begin
        if (i_motor.forward_cmd) o_cap_closed <= 1'b1;
        else if (i_motor.reverse_cmd) o_cap_closed <= 1'b0;
        // both legs on would short the bridge supply; sticky so no glitch is missed
        if (i_motor.forward_cmd && i_motor.reverse_cmd) o_fault <= 1'b1;
    end
endmodule : ipc_far
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin errors++; \
    $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module tb;
    import ipc_pkg::*;
    localparam logic [1:0] MODES [3] = '{2'h2, 2'h0, 2'h1};
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    ipc_cmd_t i_cmd = '0;
    logic i_line_pulse = 1'b0;
    logic [1:0] cart_mode = 2'h0;
    wire logic ink_pin, absent_pin, far_cap, far_fault;
    ipc_motor_t o_motor;
    logic o_valve, o_event;
    ipc_stat_t o_stat;
    int errors = 0, n_checks = 0, cycles = 0, n_ev = 0;
    logic [31:0] rnd = 32'h7C9F2D59;

    ipc_top ipc_top_inst (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_cmd(i_cmd),
        .i_line_pulse(i_line_pulse), .i_ink_empty_in(ink_pin),
        .i_cart_absent_in(absent_pin), .o_motor(o_motor), .o_valve(o_valve),
        .o_stat(o_stat), .o_event(o_event));
    ipc_far ipc_far_inst (.i_clk_sys(i_clk_sys), .i_motor(o_motor), .i_cart_mode(cart_mode),
        .o_ink_empty_in(ink_pin), .o_cart_absent_in(absent_pin), .o_cap_closed(far_cap),
        .o_fault(far_fault));

    // 100 MHz clock
    initial forever #5 i_clk_sys = ~i_clk_sys;

    // cycle ceiling and event pulse counter
    always @(posedge i_clk_sys) begin
        cycles++;
        if (o_event === 1'b1) n_ev++;
        if (cycles == 20000) begin
            errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    // step past n edges and let their updates land
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask : tick

    task automatic set_cmd(input ipc_cmd_t c);
        @(posedge i_clk_sys);
        i_cmd <= c;
    endtask : set_cmd

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    // expected {ink_empty, cart_absent, ink_end} before any line is counted
    function automatic logic [2:0] exp_sns(input logic [1:0] m);
        return (m == 2'h2) ? 3'h3 : ((m == 2'h1) ? 3'h4 : 3'h0);
    endfunction : exp_sns

    initial begin
        tick(4);
        `CHK("motor_rst", 2'h0, o_motor)
        @(posedge i_clk_sys) i_rst_n <= 1'b1;
        // forward run with valve shut: cap closes, brush turns, suction builds
        set_cmd(3'h4);
        tick(5);
        `CHK("fwd", 2'h2, o_motor)
        `CHK("fwd_stat", 7'h0F, o_stat)
        set_cmd(3'h0);
        tick(3);
        `CHK("stop", 2'h0, o_motor)
        // reverse under vacuum must vent first, motor held off meanwhile
        set_cmd(3'h2);
        tick(4);
        `CHK("vent", 3'h4, {o_valve, o_motor})
        tick(2002);
        `CHK("rev", 3'h1, {o_valve, o_motor})
        `CHK("rev_stat", 7'h08, o_stat)
        set_cmd(3'h6);
        tick(4);
        `CHK("both", 2'h0, o_motor)
        // forward with valve open pumps no ink
        set_cmd(3'h5);
        tick(5);
        `CHK("open_fwd", 3'h6, {o_valve, o_motor})
        `CHK("no_suck", 1'b0, o_stat.suction)
        set_cmd(3'h0);
        tick(4);
        `CHK("valve_off", 1'b0, o_valve)
        // cartridge walk: absent, present, empty; each change flags an event
        for (int k = 0; k < 3; k++) begin
            @(posedge i_clk_sys) cart_mode <= MODES[k];
            #1 n_ev = 0;
            tick(6);
            `CHK("sns", exp_sns(MODES[k]), {o_stat.ink_empty, o_stat.cart_absent, o_stat.ink_end})
            `CHK("event", 1'b1, n_ev > 0)
        end
        // empty pack: 199 lines leave the indication off, the 200th raises it
        for (int k = 0; k < 200; k++) begin
            @(posedge i_clk_sys) i_line_pulse <= 1'b1;
            @(posedge i_clk_sys) i_line_pulse <= 1'b0;
            if (k == 198) begin
                tick(3);
                `CHK("end199", 1'b0, o_stat.ink_end)
            end
        end
        tick(3);
        `CHK("end200", 1'b1, o_stat.ink_end)
        // random commands; the far side flags any moment both legs conduct
        for (int k = 0; k < 400; k++) begin
            rnd = lfsr(rnd);
            @(posedge i_clk_sys) i_cmd <= rnd[2:0];
            i_line_pulse <= rnd[3] & ~i_line_pulse;
        end
        set_cmd(3'h0);
        i_line_pulse <= 1'b0;
        tick(2010);
        `CHK("short", 1'b0, far_fault)
        `CHK("cap", far_cap, o_stat.cap_closed)
        end_of_test();
    end
endmodule : tb
`default_nettype wire
